// >>> logic/sfa_align.sv
`timescale 1ns/10ps

//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - SYSREF rising edge is the phase reference.
// - Aligned edge: keep phase, keep link.
// - Misaligned edge: break link, re-phase clocks.
// - Periodic: first edge aligns, later on-grid ones ignored.
// - Gapped bursts: first edge aligns.
// - Off-grid burst edge forces re-alignment.
// - Idle offset selectable: +400, -400, 0 mV.
// - Detection gate ANDed with SYSREF.
// - Gate disabled after reset.
// - Enabling gate while high makes false edge.
//////////////////////////////////////////////////////////////////////////////

module sfa_align
    import sfa_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sysref_i,
    input wire sfa_pkg::sfa_cfg_t cfg_i,
    output sfa_pkg::sfa_stat_t stat_o,
    output sfa_pkg::sfa_ofs_t ofs_sel_o,
    output logic ofs_pos_en_o,
    output logic ofs_neg_en_o
);
    import sfa_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    // Configuration holding.

    logic gate_en_r;
    sfa_ofs_t ofs_r;
    logic [SFA_CNT_W-1:0] frame_len_r;
    logic [SFA_CNT_W-1:0] k_r;

    // Gate comes up closed so no stray edge disturbs the default phase.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            gate_en_r <= 1'b0;
        end else begin
            gate_en_r <= cfg_i.gate_en;
        end
    end

    // Offset setting drives the switch network; illegal code falls to zero.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ofs_r <= SFA_OFS_ZERO;
        end else begin
            unique case (cfg_i.ofs_sel)
                SFA_OFS_POS: ofs_r <= SFA_OFS_POS;
                SFA_OFS_NEG: ofs_r <= SFA_OFS_NEG;
                SFA_OFS_ZERO: ofs_r <= SFA_OFS_ZERO;
                default: ofs_r <= SFA_OFS_ZERO;
            endcase
        end
    end

    // Counter lengths; a zero length would stall the wrap, so keep one.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            frame_len_r <= SFA_FRAME_LEN_DEF;
            k_r <= SFA_K_DEF;
        end else begin
            frame_len_r <= (cfg_i.frame_len == SFA_CNT_ZERO) ? SFA_CNT_ONE : cfg_i.frame_len;
            k_r <= (cfg_i.k_frames == SFA_CNT_ZERO) ? SFA_CNT_ONE : cfg_i.k_frames;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Edge detection and phase comparison.

    logic rise;
    logic [SFA_CNT_W-1:0] samp_ph;
    logic [SFA_CNT_W-1:0] frame_ph;
    logic on_grid;
    logic rephase;
    logic first_r;

    sfa_edge_det u_edge (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sysref_i(sysref_i),
        .gate_en_i(gate_en_r),
        .rise_o(rise)
    );

    // An edge is on grid when it lands on a multi-frame boundary.
    assign on_grid = (samp_ph == SFA_CNT_ZERO) && (frame_ph == SFA_CNT_ZERO);

    // First edge after reset always aligns; later ones only if off grid.
    // Bursts and periodic trains thus reduce to one comparison per edge.
    assign rephase = rise & (first_r | ~on_grid);

    // Tracks that no edge has yet set the phase.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            first_r <= 1'b1;
        end else if (rise) begin
            first_r <= 1'b0;
        end
    end

    sfa_phase_cnt u_cnt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .rephase_i(rephase),
        .frame_len_i(frame_len_r),
        .k_frames_i(k_r),
        .samp_o(samp_ph),
        .frame_o(frame_ph)
    );

    //////////////////////////////////////////////////////////////////////////
    // Outputs, all registered.

    // Strobes mark the start of each frame and multi-frame in the new phase.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            stat_o <= '0;
        end else begin
            stat_o.frame_strobe <= rephase | (samp_ph == SFA_CNT_ZERO);
            stat_o.lmfc_strobe <= rephase | on_grid;
            stat_o.link_break <= rephase;
            stat_o.aligned <= stat_o.aligned | rise;
        end
    end

    // Offset switch enables, one-hot from the selected setting.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ofs_sel_o <= SFA_OFS_ZERO;
            ofs_pos_en_o <= 1'b0;
            ofs_neg_en_o <= 1'b0;
        end else begin
            ofs_sel_o <= ofs_r;
            ofs_pos_en_o <= (ofs_r == SFA_OFS_POS);
            ofs_neg_en_o <= (ofs_r == SFA_OFS_NEG);
        end
    end
endmodule

// >>> logic/sfa_pkg.sv
package sfa_pkg;

    // Idle offset select codes applied to the receiver switch network.
    typedef enum logic [1:0] {
        SFA_OFS_ZERO = 2'h0,
        SFA_OFS_POS = 2'h1,
        SFA_OFS_NEG = 2'h2
    } sfa_ofs_t;

    // Width of the frame and multi-frame phase counters.
    localparam int SFA_CNT_W = 8;
    // Default samples per frame and frames per multi-frame.
    localparam logic [SFA_CNT_W-1:0] SFA_FRAME_LEN_DEF = 8'h04;
    localparam logic [SFA_CNT_W-1:0] SFA_K_DEF = 8'h20;
    // Counter reset value, the start of a frame and multi-frame.
    localparam logic [SFA_CNT_W-1:0] SFA_CNT_ZERO = 8'h00;
    localparam logic [SFA_CNT_W-1:0] SFA_CNT_ONE = 8'h01;

    // Configuration from the device's control logic.
    typedef struct packed {
        logic gate_en;
        sfa_ofs_t ofs_sel;
        logic [SFA_CNT_W-1:0] frame_len;
        logic [SFA_CNT_W-1:0] k_frames;
    } sfa_cfg_t;

    // Internal clock phase and link status.
    typedef struct packed {
        logic frame_strobe;
        logic lmfc_strobe;
        logic link_break;
        logic aligned;
    } sfa_stat_t;

endpackage

// >>> logic/sfa_edge_det.sv
`timescale 1ns/10ps

// Gated SYSREF sampler and rising-edge detector.
module sfa_edge_det (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sysref_i,
    input wire logic gate_en_i,
    output logic rise_o
);
    logic gated;
    logic samp_r;
    logic dly_r;

    // The gate ANDs the raw input so nothing passes while disabled.
    assign gated = sysref_i & gate_en_i;

    // Sample, then keep a one-cycle delayed copy for the comparison.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            samp_r <= 1'b0;
            dly_r <= 1'b0;
        end else begin
            samp_r <= gated;
            dly_r <= samp_r;
        end
    end

    // Enabling the gate while the input is high looks like an edge, on purpose.
    assign rise_o = samp_r & ~dly_r;
endmodule

// >>> logic/sfa_phase_cnt.sv
`timescale 1ns/10ps

// Free-running frame and multi-frame phase counters with a re-phase load.
module sfa_phase_cnt
    import sfa_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic rephase_i,
    input wire logic [SFA_CNT_W-1:0] frame_len_i,
    input wire logic [SFA_CNT_W-1:0] k_frames_i,
    output logic [SFA_CNT_W-1:0] samp_o,
    output logic [SFA_CNT_W-1:0] frame_o
);
    logic samp_wrap;
    logic frame_wrap;

    assign samp_wrap = (samp_o >= frame_len_i - SFA_CNT_ONE);
    assign frame_wrap = (frame_o >= k_frames_i - SFA_CNT_ONE);

    // A re-phase forces the edge cycle to be phase zero; next cycle is sample one, or sample zero when frame_len_i is 1.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            samp_o <= SFA_CNT_ZERO;
            frame_o <= SFA_CNT_ZERO;
        end else if (rephase_i) begin
            samp_o <= (frame_len_i > SFA_CNT_ONE) ? SFA_CNT_ONE : SFA_CNT_ZERO;
            frame_o <= SFA_CNT_ZERO;
        end else begin
            samp_o <= samp_wrap ? SFA_CNT_ZERO : samp_o + SFA_CNT_ONE;
            if (samp_wrap) begin
                frame_o <= frame_wrap ? SFA_CNT_ZERO : frame_o + SFA_CNT_ONE;
            end
        end
    end
endmodule

// >>> sim/sfa_align_checker.sv
`timescale 1ns/10ps
// Port-level timing checks for the aligner; offsets lag config by two edges.
module sfa_align_checker
    import sfa_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sysref_i,
    input wire sfa_pkg::sfa_cfg_t cfg_i,
    input wire sfa_pkg::sfa_stat_t stat_o,
    input wire sfa_pkg::sfa_ofs_t ofs_sel_o,
    input wire logic ofs_pos_en_o,
    input wire logic ofs_neg_en_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_break_cause: assert property (stat_o.link_break |->
        $past(sysref_i, 2) && $past(cfg_i.gate_en, 3)) else $error("break without gated edge");
    a_gate_block: assert property ((!cfg_i.gate_en)[*4] |=> !stat_o.link_break)
        else $error("break while gate closed");
    a_break_pulse: assert property (stat_o.link_break |=> !stat_o.link_break)
        else $error("break longer than one cycle");
    a_break_phase: assert property (stat_o.link_break |->
        stat_o.lmfc_strobe && stat_o.frame_strobe && stat_o.aligned) else $error("no re-phase");
    a_aligned_keep: assert property (stat_o.aligned |=> stat_o.aligned)
        else $error("alignment lost");
    a_align_first: assert property ($rose(stat_o.aligned) |-> stat_o.link_break)
        else $error("aligned without break");
    a_ofs_pos: assert property (ofs_pos_en_o == ($past(cfg_i.ofs_sel, 2) == SFA_OFS_POS))
        else $error("positive switch wrong");
    a_ofs_neg: assert property (ofs_neg_en_o == ($past(cfg_i.ofs_sel, 2) == SFA_OFS_NEG))
        else $error("negative switch wrong");
    c_break: cover property (stat_o.link_break);
    c_gate_high: cover property ($rose(cfg_i.gate_en) && sysref_i);
    c_neg: cover property (ofs_neg_en_o);
endmodule
bind sfa_align sfa_align_checker chk (.clk_i, .rst_i, .sysref_i, .cfg_i, .stat_o, .ofs_sel_o,
    .ofs_pos_en_o, .ofs_neg_en_o);

// >>> sim/sfa_sysref_src.sv
`timescale 1ns/10ps
// SYSREF source: a trigger raises the line for HOLD cycles, then it idles low.
module sfa_sysref_src #(parameter int HOLD = 8) (
    input wire logic clk_i,
    input wire logic trig_i,
    output logic sysref_o
);
    int cnt = 0;
    // Hold covers four frames and half a multi-frame, inside the duty limits.
    always @(posedge clk_i) begin
        if (trig_i)
            cnt <= HOLD;
        else if (cnt > 0)
            cnt <= cnt - 1;
    end
    assign sysref_o = cnt > 0;
endmodule

// >>> sim/sfa_align_test.sv
`timescale 1ns/10ps
module sfa_align_test;
    import sfa_pkg::*;
    logic clk_i = 0;
    logic rst_i = 1;
    logic trig = 0;
    logic sysref_i, pos, neg;
    sfa_cfg_t cfg = '{1'b0, SFA_OFS_ZERO, 8'h02, 8'h08};
    sfa_stat_t stat;
    sfa_ofs_t ofs;
    int n_mismatch = 0, compares = 0, cyc = 0;
    int q[$];
    logic [31:0] rs = 32'h0000_7597;
    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) cyc <= cyc + 1;
    sfa_sysref_src src (.clk_i, .trig_i(trig), .sysref_o(sysref_i));
    sfa_align dut (.clk_i, .rst_i, .sysref_i, .cfg_i(cfg), .stat_o(stat), .ofs_sel_o(ofs),
        .ofs_pos_en_o(pos), .ofs_neg_en_o(neg));
    ////////////////////////////////////////////////////////////////
    function logic [31:0] xs();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    task chk(string nm, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task end_sim;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // An edge launched here shows its break four edges later, multi-frame is 16 cycles.
    task go(int gap, bit brk);
        repeat (gap - 1) @(posedge clk_i);
        trig <= 1;
        if (brk) q.push_back(cyc + 4);
        @(posedge clk_i);
        trig <= 0;
    endtask
    // Each break takes the oldest noted cycle; a stray break meets an empty queue.
    always @(posedge clk_i) begin
        if (stat.link_break === 1'b1) begin
            chk("break_cycle", cyc, q.size() > 0 ? q.pop_front() : 0);
            chk("break_state", {stat.frame_strobe, stat.lmfc_strobe, stat.aligned}, 3'h7);
        end
    end
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 0;
        for (int i = 0; i < 4; i++) begin
            cfg.ofs_sel <= sfa_ofs_t'(i);
            repeat (3) @(posedge clk_i);
            chk("ofs", {ofs, pos, neg}, i == 1 ? 4'h6 : i == 2 ? 4'h9 : 4'h0);
        end
        // Source idles low on an AC-coupled line, so the offset stays negative.
        cfg.ofs_sel <= SFA_OFS_NEG;
        go(20, 0);
        repeat (4) @(posedge clk_i);
        chk("aligned", stat.aligned, 1'b0);
        cfg.gate_en <= 1'b1;
        q.push_back(cyc + 4);
        go(19, 1);
        // The aligned burst spans 96 cycles, under 5 us at this clock.
        for (int n = 1; n < 4; n++) go(16 * n, 0);
        for (int j = 0; j < 6; j++) begin
            go(17 + xs() % 15, 1);
            go(16, 0);
        end
        repeat (8) @(posedge clk_i);
        chk("pending", q.size(), 0);
        end_sim;
    end
    // The run needs well under 1000 cycles; this cuts a hang short.
    initial begin
        #200000;
        n_mismatch++;
        end_sim;
    end
endmodule
